// *** csw_consts.svh ***
`ifndef CSW_CONSTS_SVH
`define CSW_CONSTS_SVH
`define CSW_CLK_HZ 100000000
`define CSW_TB0_PERIOD_MS 100
`define CSW_TB1_PERIOD_MS 200
`define CSW_TB2_PERIOD_MS 1000
`define CSW_HALF_CYCLES(ms) (((ms) * (`CSW_CLK_HZ / 1000)) / 2)
`define CSW_IRQ_UNIT_US 100
`define CSW_TICK_CYCLES (`CSW_IRQ_UNIT_US * (`CSW_CLK_HZ / 1000000))
`define CSW_IDX_TB 12'h0ff
`define CSW_IDX_RSVD_LO 12'h100
`define CSW_IDX_RSVD_HI 12'h105
`define CSW_IDX_IRQ_TIME 12'h106
`define CSW_IDX_IRQ_NUM 12'h107
`define CSW_IDX_SERIAL 12'h108
`define CSW_IDX_LINK 12'h109
`define CSW_IDX_CFG 12'h10a
`define CSW_WORD_RST 16'h0000
`define CSW_BUS_RST 32'h00000000
`define CSW_TB_N 3
`define CSW_AR_N 5
`define CSW_AR_LO 3
`define CSW_TR_HI 15
`define CSW_TR_LO 8
`define CSW_S_RERR 4
`define CSW_S_RDONE 6
`define CSW_S_ROVF 7
`define CSW_S_PERR 12
`define CSW_S_PDONE 14
`define CSW_S_POVF 15
`define CSW_STK_N 6
`define CSW_CFG_RS 0
`define CSW_CFG_GIO 1
`define CSW_IRQ_FLAG 1'h1
`define CSW_CODE_NONE 4'h0
`define CSW_TICK_MAX 16'hffff
`endif

// *** csw_pkg.sv ***
package csw_pkg;
    typedef logic [15:0] csw_word_t;
    typedef logic [31:0] csw_bus_t;
    typedef enum logic {CSW_LINK_TERM, CSW_LINK_RS232} csw_link_e;
endpackage : csw_pkg

// *** csw_timebase.sv ***
`timescale 1ns/1ps
module csw_timebase #(
    parameter int unsigned HALF = 32'h00000002
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic pulse_o
);
    logic [31:0] cnt_r;
    logic wrap;

    assign wrap = (cnt_r == HALF - 32'h00000001);

    // free-running divider, equal high and low halves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 32'h00000000;
        end else if (wrap) begin
            cnt_r <= 32'h00000000;
        end else begin
            cnt_r <= cnt_r + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_o <= 1'h0;
        end else if (wrap) begin
            pulse_o <= ~pulse_o;
        end
    end

    a_tb_edge_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(pulse_o) |-> $past(wrap))
        else $error("timebase moved without divider wrap");
    a_tb_flip_done: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> pulse_o != $past(pulse_o))
        else $error("timebase did not toggle at wrap");
endmodule : csw_timebase

// *** csw_bank.sv ***
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "csw_consts.svh"
// Functional notes
// - word 255 bit 0: 0.1 s clock
// - word 255 bit 1: 0.2 s clock
// - word 255 bit 2: 1.0 s clock
// - bits 3-7 arithmetic flags, cleared at program end
// - word 262 longest handler time, 0.1 ms
// - word 263 longest handler number, bit 15 flag
// - word 264 bits 0-3 primary port error code
// - bit 4 primary port communications error
// - bit 5 primary port send ready
// - bit 6 primary port reception completed
// - bit 7 primary port reception overflow
// - bits 8-11 peripheral error code, general mode
// - bit 12 peripheral port communications error
// - bit 13 peripheral send ready, general mode
// - bit 14 peripheral reception completed, general mode
// - bit 15 peripheral reception overflow, general mode
// - word 265 terminal active and priority flags
// - word 265 receive count in serial mode
// - flags low until their condition arises
module csw_bank #(
    parameter int unsigned TB0_HALF = `CSW_HALF_CYCLES(`CSW_TB0_PERIOD_MS),
    parameter int unsigned TB1_HALF = `CSW_HALF_CYCLES(`CSW_TB1_PERIOD_MS),
    parameter int unsigned TB2_HALF = `CSW_HALF_CYCLES(`CSW_TB2_PERIOD_MS),
    parameter int unsigned IRQ_TICK = `CSW_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire csw_pkg::csw_bus_t wb_dat_i,
    output csw_pkg::csw_bus_t wb_dat_o,
    output logic wb_ack_o,
    output wire logic [2:0] tb_pulse_o,
    output logic [4:0] arith_flags_o,
    input wire logic prog_end_i,
    input wire logic [4:0] arith_set_i,
    input wire logic irq_start_i,
    input wire logic irq_end_i,
    input wire logic [7:0] irq_num_i,
    input wire logic rs_err_i,
    input wire logic [3:0] rs_err_code_i,
    input wire logic rs_send_ready_i,
    input wire logic rs_rx_done_i,
    input wire logic rs_rx_ovf_i,
    input wire logic rs_rx_byte_i,
    input wire logic pp_err_i,
    input wire logic [3:0] pp_err_code_i,
    input wire logic pp_send_ready_i,
    input wire logic pp_rx_done_i,
    input wire logic pp_rx_ovf_i,
    input wire logic [7:0] term_active_i,
    input wire logic [7:0] term_prio_i
);
    import csw_pkg::*;

    localparam int unsigned TB_HALF [`CSW_TB_N] = '{TB0_HALF, TB1_HALF, TB2_HALF};
    localparam int unsigned STK_POS [`CSW_STK_N] = '{`CSW_S_RERR, `CSW_S_RDONE, `CSW_S_ROVF,
                                                     `CSW_S_PERR, `CSW_S_PDONE, `CSW_S_POVF};

    logic [11:0] idx;
    logic req;
    logic wr_en;
    logic [15:0] wmask;
    logic wr_tb;
    logic wr_ser;
    logic wr_link;
    logic wr_cfg;
    csw_word_t rd_word;

    logic [7:0] tr_r;
    csw_link_e link_mode_r;
    logic gio_r;
    logic [5:0] stk_r;
    logic [5:0] stk_set;
    logic [5:0] stk_keep;
    logic [3:0] rs_code_r;
    logic [3:0] pp_code_r;
    logic rs_ready_r;
    logic pp_ready_r;
    csw_word_t ser_word;
    logic [7:0] term_act_r;
    logic [7:0] term_pri_r;
    csw_word_t rx_cnt_r;
    csw_word_t link_word;

    logic irq_busy_r;
    logic [31:0] sub_r;
    logic tick;
    csw_word_t ticks_r;
    logic [7:0] irq_cur_r;
    csw_word_t irq_max_r;
    csw_word_t irq_id_r;
    logic irq_new_max;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // bus decode, one register per aligned word
    assign idx = wb_adr_i[13:2];
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_en = req & wb_we_i & wb_ack_o;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_tb = wr_en && (idx == `CSW_IDX_TB);
    assign wr_ser = wr_en && (idx == `CSW_IDX_SERIAL);
    assign wr_link = wr_en && (idx == `CSW_IDX_LINK);
    assign wr_cfg = wr_en && (idx == `CSW_IDX_CFG);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `CSW_BUS_RST;
        end else if (req & ~wb_ack_o) begin
            wb_dat_o <= {`CSW_WORD_RST, rd_word};
        end
    end

    always_comb begin
        rd_word = `CSW_WORD_RST;
        if (idx == `CSW_IDX_TB) begin
            rd_word = {tr_r, arith_flags_o, tb_pulse_o};
        end else if (idx >= `CSW_IDX_RSVD_LO && idx <= `CSW_IDX_RSVD_HI) begin
            rd_word = `CSW_WORD_RST;
        end else if (idx == `CSW_IDX_IRQ_TIME) begin
            rd_word = irq_max_r;
        end else if (idx == `CSW_IDX_IRQ_NUM) begin
            rd_word = irq_id_r;
        end else if (idx == `CSW_IDX_SERIAL) begin
            rd_word = ser_word;
        end else if (idx == `CSW_IDX_LINK) begin
            rd_word = link_word;
        end else if (idx == `CSW_IDX_CFG) begin
            rd_word = {14'h0000, gio_r, link_mode_r};
        end
    end

    // timebase dividers
    for (genvar g = 0; g < `CSW_TB_N; g++) begin : g_tb
        csw_timebase #(
            .HALF(TB_HALF[g])
        ) u_tb (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pulse_o(tb_pulse_o[g])
        );
    end

    // arithmetic flags: set beats write beats end-of-program clear
    for (genvar b = 0; b < `CSW_AR_N; b++) begin : g_arith
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                arith_flags_o[b] <= 1'h0;
            end else if (arith_set_i[b]) begin
                arith_flags_o[b] <= 1'h1;
            end else if (wr_tb && wmask[`CSW_AR_LO + b]) begin
                arith_flags_o[b] <= wb_dat_i[`CSW_AR_LO + b];
            end else if (prog_end_i) begin
                arith_flags_o[b] <= 1'h0;
            end
        end
    end

    // branch scratch bits, plain storage for the program
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tr_r <= 8'h00;
        end else if (wr_tb && wb_sel_i[1]) begin
            tr_r <= wb_dat_i[`CSW_TR_HI:`CSW_TR_LO];
        end
    end

    // mode configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_mode_r <= CSW_LINK_TERM;
            gio_r <= 1'h0;
        end else if (wr_cfg && wb_sel_i[0]) begin
            link_mode_r <= csw_link_e'(wb_dat_i[`CSW_CFG_RS]);
            gio_r <= wb_dat_i[`CSW_CFG_GIO];
        end
    end

    // sticky serial flags, write one to clear, set wins
    assign stk_set = {pp_rx_ovf_i, pp_rx_done_i, pp_err_i, rs_rx_ovf_i, rs_rx_done_i, rs_err_i};
    assign stk_keep = {gio_r, gio_r, 1'h1, 1'h1, 1'h1, 1'h1};

    for (genvar s = 0; s < `CSW_STK_N; s++) begin : g_stk
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                stk_r[s] <= 1'h0;
            end else begin
                stk_r[s] <= stk_keep[s] & (stk_set[s] |
                    (stk_r[s] & ~(wr_ser & wmask[STK_POS[s]] & wb_dat_i[STK_POS[s]])));
            end
        end
    end

    // error codes follow the error event, cleared with their flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rs_code_r <= `CSW_CODE_NONE;
        end else if (rs_err_i) begin
            rs_code_r <= rs_err_code_i;
        end else if (wr_ser && wmask[`CSW_S_RERR] && wb_dat_i[`CSW_S_RERR]) begin
            rs_code_r <= `CSW_CODE_NONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pp_code_r <= `CSW_CODE_NONE;
        end else if (!gio_r) begin
            pp_code_r <= `CSW_CODE_NONE;
        end else if (pp_err_i) begin
            pp_code_r <= pp_err_code_i;
        end else if (wr_ser && wmask[`CSW_S_PERR] && wb_dat_i[`CSW_S_PERR]) begin
            pp_code_r <= `CSW_CODE_NONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rs_ready_r <= 1'h0;
            pp_ready_r <= 1'h0;
        end else begin
            rs_ready_r <= rs_send_ready_i;
            pp_ready_r <= gio_r & pp_send_ready_i;
        end
    end

    assign ser_word = {stk_r[5], stk_r[4], pp_ready_r, stk_r[3], pp_code_r,
                       stk_r[2], stk_r[1], rs_ready_r, stk_r[0], rs_code_r};

    // terminal link flags and receive counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_act_r <= 8'h00;
            term_pri_r <= 8'h00;
        end else begin
            term_act_r <= term_active_i;
            term_pri_r <= term_prio_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_cnt_r <= `CSW_WORD_RST;
        end else if (link_mode_r == CSW_LINK_RS232 && rs_rx_byte_i) begin
            rx_cnt_r <= wr_link ? 16'h0001 : rx_cnt_r + 16'h0001;
        end else if (wr_link) begin
            rx_cnt_r <= `CSW_WORD_RST;
        end
    end

    assign link_word = (link_mode_r == CSW_LINK_RS232) ? rx_cnt_r : {term_pri_r, term_act_r};

    // interrupt handler timing in 0.1 ms ticks
    assign tick = (sub_r == IRQ_TICK - 32'h00000001);
    assign irq_new_max = irq_end_i && irq_busy_r && (ticks_r > irq_max_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_busy_r <= 1'h0;
            irq_cur_r <= 8'h00;
        end else if (irq_start_i) begin
            irq_busy_r <= 1'h1;
            irq_cur_r <= irq_num_i;
        end else if (irq_end_i) begin
            irq_busy_r <= 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || irq_start_i || tick) begin
            sub_r <= 32'h00000000;
        end else if (irq_busy_r) begin
            sub_r <= sub_r + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || irq_start_i) begin
            ticks_r <= `CSW_WORD_RST;
        end else if (irq_busy_r && tick && ticks_r != `CSW_TICK_MAX) begin
            ticks_r <= ticks_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_max_r <= `CSW_WORD_RST;
            irq_id_r <= `CSW_WORD_RST;
        end else if (irq_new_max) begin
            irq_max_r <= ticks_r;
            irq_id_r <= {`CSW_IRQ_FLAG, 7'h00, irq_cur_r};
        end
    end

    sequence s_req;
        req && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_ack_once: assert property (s_req |=> s_ack_pulse)
        else $error("bus answer not a single-cycle ack");
    a_bus_rd_data: assert property (s_req and idx == `CSW_IDX_SERIAL |=> wb_dat_o[15:0] == $past(ser_word))
        else $error("read data does not match serial status");
    a_arith_end_clr: assert property (prog_end_i && !(|arith_set_i) && !wr_tb |=> arith_flags_o == 5'h00)
        else $error("arithmetic flags survived program end");
    a_arith_set_win: assert property (|arith_set_i |=> (arith_flags_o & $past(arith_set_i)) == $past(arith_set_i))
        else $error("arithmetic flag set lost");
    a_tb_read_bits: assert property (s_req and idx == `CSW_IDX_TB |=> wb_dat_o[2:0] == $past(tb_pulse_o))
        else $error("timebase bits not read back");
    a_rs_code_latch: assert property (rs_err_i |=> rs_code_r == $past(rs_err_code_i) && stk_r[0])
        else $error("primary error code or flag not captured");
    a_rs_ready_follow: assert property (##1 rs_ready_r == $past(rs_send_ready_i))
        else $error("primary send ready does not follow port");
    a_rs_done_set: assert property (rs_rx_done_i |=> stk_r[1])
        else $error("primary reception completed not set");
    a_rs_ovf_set: assert property (rs_rx_ovf_i |=> stk_r[2])
        else $error("primary overflow not set");
    a_pp_err_set: assert property (pp_err_i |=> stk_r[3])
        else $error("peripheral error flag not set");
    a_pp_mode_gate: assert property (!gio_r |=> !pp_ready_r && !stk_r[4] && !stk_r[5] && pp_code_r == 4'h0)
        else $error("peripheral general-mode flags active outside mode");
    a_pp_done_set: assert property (gio_r && pp_rx_done_i && !wr_cfg |=> stk_r[4])
        else $error("peripheral reception completed not set");
    a_pp_ovf_set: assert property (gio_r && pp_rx_ovf_i && !wr_cfg |=> stk_r[5]
        && (pp_code_r == $past(pp_code_r) || $past(pp_err_i) || $past(wr_ser)))
        else $error("peripheral overflow not set");
    a_pp_code_cap: assert property (gio_r && pp_err_i && !wr_cfg |=> pp_code_r == $past(pp_err_code_i))
        else $error("peripheral error code not captured");
    a_term_read: assert property (s_req and idx == `CSW_IDX_LINK && link_mode_r == CSW_LINK_TERM
        |=> wb_dat_o[15:0] == $past({term_pri_r, term_act_r}))
        else $error("terminal flags not read back");
    a_rx_count_inc: assert property (link_mode_r == CSW_LINK_RS232 && rs_rx_byte_i && !wr_link
        |=> rx_cnt_r == $past(rx_cnt_r) + 16'h0001)
        else $error("receive counter did not advance");
    a_irq_max_keep: assert property (irq_new_max |=> irq_max_r == $past(ticks_r))
        else $error("longest handler time not recorded");
    a_irq_num_keep: assert property (irq_new_max |=> irq_id_r == {1'h1, 7'h00, $past(irq_cur_r)})
        else $error("longest handler number not recorded");
    a_irq_no_shrink: assert property (!irq_new_max |=> irq_max_r == $past(irq_max_r))
        else $error("longest handler time changed without cause");
    a_reset_low: assert property (@(posedge clk_i) disable iff (1'h0) rst_i |=> stk_r == 6'h00
        && arith_flags_o == 5'h00 && irq_id_r == 16'h0000)
        else $error("flags not low after reset");
endmodule : csw_bank

// *** csw_peer.sv ***
`timescale 1ns/1ps
module csw_peer (
    input wire logic clk_i,
    output logic [6:0] evt_o,
    output logic [3:0] rs_code_o,
    output logic [3:0] pp_code_o,
    output logic rs_ready_o,
    output logic pp_ready_o,
    output logic [7:0] term_active_o,
    output logic [7:0] term_prio_o
);
    // event bits: 0 rs err, 1 rs done, 2 rs ovf, 3 rs byte, 4 pp err, 5 pp done, 6 pp ovf
    initial begin
        evt_o = 7'h00;
        rs_code_o = 4'h0;
        pp_code_o = 4'h0;
        rs_ready_o = 1'b0;
        pp_ready_o = 1'b0;
        term_active_o = 8'h00;
        term_prio_o = 8'h00;
    end
    task ev(input int k, input logic [3:0] c);
        @(posedge clk_i);
        evt_o <= 7'h01 << k;
        rs_code_o <= c;
        pp_code_o <= c;
        @(posedge clk_i);
        evt_o <= 7'h00;
        // code is only valid beside its strobe, so it shows garbage afterwards
        rs_code_o <= ~c;
        pp_code_o <= ~c;
    endtask : ev
    task levels(input logic rr, input logic pr, input logic [7:0] a, input logic [7:0] p);
        @(posedge clk_i);
        rs_ready_o <= rr;
        pp_ready_o <= pr;
        term_active_o <= a;
        term_prio_o <= p;
    endtask : levels
endmodule : csw_peer

// *** controller_status_word_bank_tb.sv ***
`timescale 1ns/1ps
module controller_status_word_bank_tb;
    import csw_pkg::*;
    localparam int TK = 5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, prog_end = 1'b0, irq_s = 1'b0, irq_e = 1'b0;
    logic [13:0] adr = 14'h0000;
    logic [3:0] sel = 4'h0;
    logic [4:0] aset = 5'h00;
    logic [7:0] inum = 8'h00;
    csw_bus_t wdat = 32'h00000000;
    csw_bus_t rdat;
    logic ack;
    logic [2:0] tbp;
    logic [4:0] aflags;
    logic [6:0] evt;
    logic [3:0] rs_code, pp_code;
    logic rs_rdy, pp_rdy;
    logic [7:0] t_act, t_pri;
    csw_word_t q;
    int err_count = 0;
    int n_compared = 0;
    always #5 clk_i = ~clk_i;
    csw_peer peer (.clk_i(clk_i), .evt_o(evt), .rs_code_o(rs_code), .pp_code_o(pp_code),
        .rs_ready_o(rs_rdy), .pp_ready_o(pp_rdy), .term_active_o(t_act), .term_prio_o(t_pri));
    csw_bank #(.TB0_HALF(4), .TB1_HALF(8), .TB2_HALF(20), .IRQ_TICK(TK)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tb_pulse_o(tbp), .arith_flags_o(aflags), .prog_end_i(prog_end), .arith_set_i(aset),
        .irq_start_i(irq_s), .irq_end_i(irq_e), .irq_num_i(inum),
        .rs_err_i(evt[0]), .rs_err_code_i(rs_code), .rs_send_ready_i(rs_rdy),
        .rs_rx_done_i(evt[1]), .rs_rx_ovf_i(evt[2]), .rs_rx_byte_i(evt[3]),
        .pp_err_i(evt[4]), .pp_err_code_i(pp_code), .pp_send_ready_i(pp_rdy),
        .pp_rx_done_i(evt[5]), .pp_rx_ovf_i(evt[6]), .term_active_i(t_act), .term_prio_i(t_pri));
    task results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task hang;
        err_count++;
        $display("[ERR] %0t wait limit reached", $time);
        results();
    endtask : hang
    task chk_word(input csw_word_t got, input csw_word_t exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_n
    task wb(input logic [11:0] idx, input logic w, input csw_word_t d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) hang();
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd(input logic [11:0] idx, input csw_word_t exp, input csw_word_t m);
        wb(idx, 1'b0, 16'h0000, 4'h3);
        chk_word(q & m, exp);
    endtask : rd
    task wait_lvl(input int i, input logic v);
        int n;
        n = 0;
        while (tbp[i] !== v && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200) hang();
    endtask : wait_lvl
    task tb_half(input int i, input int exp);
        int n;
        wait_lvl(i, 1'b0);
        wait_lvl(i, 1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tbp[i] === 1'b1 && n < 200);
        chk_n(n, exp);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tbp[i] === 1'b0 && n < 200);
        chk_n(n, exp);
    endtask : tb_half
    task pulse_in(input int k);
        @(posedge clk_i);
        if (k == 0) prog_end <= 1'b1;
        if (k == 1) aset <= 5'h1f;
        if (k == 2) irq_s <= 1'b1;
        if (k == 3) irq_e <= 1'b1;
        @(posedge clk_i);
        prog_end <= 1'b0;
        aset <= 5'h00;
        irq_s <= 1'b0;
        irq_e <= 1'b0;
    endtask : pulse_in
    task irq_run(input logic [7:0] num, input int g);
        inum <= num;
        pulse_in(2);
        repeat (g - 1) @(posedge clk_i);
        pulse_in(3);
    endtask : irq_run
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h108, 16'h0000, 16'hffff);
        rd(12'h106, 16'h0000, 16'hffff);
        tb_half(0, 4);
        tb_half(1, 8);
        tb_half(2, 20);
        pulse_in(1);
        @(posedge clk_i);
        chk_word({11'h000, aflags}, 16'h001f);
        rd(12'h0ff, 16'h00f8, 16'hfff8);
        wb(12'h0ff, 1'b1, 16'h0050, 4'h1);
        rd(12'h0ff, 16'h0050, 16'hfff8);
        pulse_in(0);
        rd(12'h0ff, 16'h0000, 16'hfff8);
        chk_word({11'h000, aflags}, 16'h0000);
        irq_run(8'h2a, 21);
        rd(12'h106, 16'((21 + 1) / TK), 16'hffff);
        rd(12'h107, 16'h802a, 16'hffff);
        irq_run(8'h11, 6);
        rd(12'h107, 16'h802a, 16'hffff);
        irq_run(8'hff, 41);
        rd(12'h106, 16'((41 + 1) / TK), 16'hffff);
        rd(12'h107, 16'h80ff, 16'hffff);
        wb(12'h106, 1'b1, 16'h1234, 4'h3);
        rd(12'h106, 16'((41 + 1) / TK), 16'hffff);
        wb(12'h10a, 1'b1, 16'h0002, 4'h3);
        peer.levels(1'b1, 1'b1, 8'h81, 8'h24);
        for (int c = 0; c < 4; c++) begin
            peer.ev(0, c[3:0]);
            peer.ev(4, c[3:0]);
            rd(12'h108, 16'h3030 | 16'(c) | (16'(c) << 8), 16'hffff);
        end
        for (int k = 1; k < 7; k++) begin
            if (k != 3 && k != 4) peer.ev(k, 4'h0);
        end
        rd(12'h108, 16'hf3f3, 16'hffff);
        wb(12'h108, 1'b1, 16'hd0d0, 4'h3);
        rd(12'h108, 16'h2020, 16'hffff);
        wb(12'h10a, 1'b1, 16'h0000, 4'h3);
        rd(12'h108, 16'h0020, 16'hffff);
        rd(12'h109, 16'h2481, 16'hffff);
        wb(12'h10a, 1'b1, 16'h0001, 4'h3);
        repeat (3) peer.ev(3, 4'h0);
        rd(12'h109, 16'h0003, 16'hffff);
        wb(12'h109, 1'b1, 16'h0000, 4'h1);
        rd(12'h109, 16'h0000, 16'hffff);
        wb(12'h100, 1'b1, 16'hffff, 4'h3);
        rd(12'h100, 16'h0000, 16'hffff);
        rd(12'h3ff, 16'h0000, 16'hffff);
        results();
    end
endmodule : controller_status_word_bank_tb
